// [core/hbs_pkg.sv]
package hbs_pkg;

  // ---------------------------------------------------------------
  // frame and field layout
  // ---------------------------------------------------------------
  localparam int NUM_BRIDGES = 6;
  localparam int WORD_W      = 16;
  localparam int MIN_BITS    = 16;  // first block of a frame
  localparam int STEP_BITS   = 8;   // chained devices add whole bytes
  localparam int STEP_LSB_W  = 3;   // log2 of STEP_BITS
  localparam int FCNT_W      = 10;  // frame bit counter width

  // status word bit positions
  localparam int ST_OC_BIT   = 15;
  localparam int ST_PSF_BIT  = 14;
  localparam int ST_ULD_BIT  = 13;
  localparam int ST_HB_LSB   = 1;
  localparam int ST_TW_BIT   = 0;

  // per-bridge status codes
  localparam logic [1:0] HB_OFF = 2'h0;
  localparam logic [1:0] HB_OC  = 2'h1;
  localparam logic [1:0] HB_ULD = 2'h2;
  localparam logic [1:0] HB_ON  = 2'h3;

  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS    = 100;
  localparam int DEAD_NS   = 1000;  // both dead times, plain default
  localparam int DEAD_CYC  = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_W    = 8;
  localparam int FIFO_DEPTH = 8;

  // command word as it arrives, msb first
  typedef struct packed {
    logic                   fault_clear_request;
    logic                   bridge_select;
    logic                   uld_shutdown_en;
    logic [NUM_BRIDGES-1:0] bridge_enable_bit;
    logic [NUM_BRIDGES-1:0] bridge_config_bit;
    logic                   ovlo_en;
  } hbs_cmd_s;

  // frame phase of the serial port
  typedef enum logic [0:0] {
    SPI_IDLE,
    SPI_FRAME
  } hbs_spi_e;

endpackage : hbs_pkg

// [core/hbs_fifo.sv]
`timescale 1ns/10ps
`default_nettype none

module hbs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // honest full and empty
  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_ff[rd_ff];

  // storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : hbs_fifo

`default_nettype wire

// [core/hbs_core.sv]
// Operation
// - status word: overcurrent bit 15, supply fail 14, underload 13, warning 0.
// - six two-bit bridge fields bits 12..1: off, overcurrent, underload, enabled.
// - overcurrent after underload changes that field from underload to overcurrent.
// - no path overcurrent to underload; underload shown only after clearing.
// - serial output shows latched thermal shutdown until first rising clock.
// - command bits 12..1 steer the six bridges.
// - enable 0 means high impedance; config picks low or high side.
// - never both sides on; dead time between off and on.
// - frame valid only with 16 bits then whole bytes.
// - invalid frame discarded, outputs keep previous state.
// - long but length-valid frame accepted with latest 16 bits.
// - shutdown flag ORed with serial input onto output.
// - reset clears counters, shift registers, registers; drivers off.
// - drivers stay on until supply fault, command or fault.
// - logic state kept across driver supply range while logic valid.
// - msb first, input on falling clock, output on rising clock.
// - valid frame end loads last 16 bits; output off while deselected.
// - command bit 15 clears all latched faults.
// - enable input low clears registers and drivers.
`timescale 1ns/10ps
`default_nettype none

module hbs_core #(
  parameter int NB       = hbs_pkg::NUM_BRIDGES,
  parameter int DEAD_CYC = hbs_pkg::DEAD_CYC
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // device enable pin
  input  wire logic          enable,
  // serial pins, asynchronous to clock
  input  wire logic          sclk,
  input  wire logic          chip_select_n,
  input  wire logic          si,
  output logic               so,
  output logic               so_oe,
  // fault detectors, same clock domain
  input  wire logic [NB-1:0] oc_det,
  input  wire logic [NB-1:0] uld_det,
  input  wire logic [NB-1:0] tsd_det,
  input  wire logic          tw_det,
  input  wire logic          uv_det,
  input  wire logic          ov_det,
  // switch commands
  output logic      [NB-1:0] high_side_switch,
  output logic      [NB-1:0] low_side_switch
);

  localparam int W = hbs_pkg::WORD_W;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------

  // overcurrent outranks underload, so a field never goes 01 -> 10
  function automatic logic [1:0] hb_code(input logic oc, input logic underload_flag,
                                         input logic en);
    if (oc) begin
      hb_code = hbs_pkg::HB_OC;
    end else if (underload_flag) begin
      hb_code = hbs_pkg::HB_ULD;
    end else if (en) begin
      hb_code = hbs_pkg::HB_ON;
    end else begin
      hb_code = hbs_pkg::HB_OFF;
    end
  endfunction : hb_code

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic       sclk_d_ff;
  logic       csn_d_ff;

  // first stage is read only by the second
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      // idle pin levels, so no false clock edge follows reset
      sync1_ff  <= 4'hA;
      sync2_ff  <= 4'hA;
      sclk_d_ff <= 1'b0;
      csn_d_ff  <= 1'b1;
    end else begin
      sync1_ff  <= {enable, sclk, chip_select_n, si};
      sync2_ff  <= sync1_ff;
      sclk_d_ff <= sync2_ff[2];
      csn_d_ff  <= sync2_ff[1];
    end
  end

  logic en_s;
  logic sclk_s;
  logic csn_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  assign en_s      = sync2_ff[3];
  assign sclk_s    = sync2_ff[2];
  assign csn_s     = sync2_ff[1];
  assign si_s      = sync2_ff[0];
  assign sclk_rise = sclk_s && !sclk_d_ff && !csn_s;
  assign sclk_fall = !sclk_s && sclk_d_ff && !csn_s;
  assign cs_fall   = !csn_s && csn_d_ff;
  assign cs_rise   = csn_s && !csn_d_ff;

  // ---------------------------------------------------------------
  // latched faults and status word
  // ---------------------------------------------------------------
  hbs_pkg::hbs_cmd_s cmd_ff;
  logic [NB-1:0]     oc_ff;
  logic [NB-1:0]     uld_ff;
  logic [NB-1:0]     tsd_ff;
  logic              clr;
  logic [W-1:0]      status;
  logic [2*NB-1:0]   hb_fields;

  // fault latches; a new event wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oc_ff  <= '0;
      uld_ff <= '0;
      tsd_ff <= '0;
    end else if (!en_s) begin
      oc_ff  <= '0;
      uld_ff <= '0;
      tsd_ff <= '0;
    end else begin
      oc_ff  <= oc_det | (oc_ff & ~{NB{clr}});
      tsd_ff <= tsd_det | (tsd_ff & ~{NB{clr}});
      uld_ff <= (uld_det & ~oc_ff) | (uld_ff & ~{NB{clr}});
    end
  end

  // bridge six in the top field
  generate
    for (genvar b = 0; b < NB; b++) begin : g_code
      assign hb_fields[2*b +: 2] = hb_code(oc_ff[b], uld_ff[b],
                                           cmd_ff.bridge_enable_bit[b]);
    end
  endgenerate

  always_comb begin
    status = hbs_pkg::WORD_RST;
    status[hbs_pkg::ST_OC_BIT]  = |oc_ff;
    status[hbs_pkg::ST_PSF_BIT] = uv_det || ov_det;
    status[hbs_pkg::ST_ULD_BIT] = |uld_ff;
    status[hbs_pkg::ST_HB_LSB +: 2*NB] = hb_fields;
    status[hbs_pkg::ST_TW_BIT]  = tw_det;
  end

  // ---------------------------------------------------------------
  // serial frame engine
  // ---------------------------------------------------------------
  hbs_pkg::hbs_spi_e          spi_ff;
  logic [W-1:0]               in_sr_ff;
  logic [W-1:0]               out_sr_ff;
  logic [hbs_pkg::FCNT_W-1:0] bits_ff;
  logic                       bits_ovf_ff;
  logic                       first_ff;
  logic                       frame_ok;

  assign frame_ok = !bits_ovf_ff
                 && (bits_ff >= hbs_pkg::FCNT_W'(hbs_pkg::MIN_BITS))
                 && (bits_ff[hbs_pkg::STEP_LSB_W-1:0] == '0);

  // frame phase follows the select line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spi_ff <= hbs_pkg::SPI_IDLE;
    end else begin
      case (spi_ff)
        hbs_pkg::SPI_IDLE:  if (cs_fall && en_s) spi_ff <= hbs_pkg::SPI_FRAME;
        hbs_pkg::SPI_FRAME: if (csn_s || !en_s) spi_ff <= hbs_pkg::SPI_IDLE;
        default:            spi_ff <= hbs_pkg::SPI_IDLE;
      endcase
    end
  end

  // counters and shift registers cleared by reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_sr_ff    <= hbs_pkg::WORD_RST;
      bits_ff     <= '0;
      bits_ovf_ff <= 1'b0;
    end else if (cs_fall || !en_s) begin
      in_sr_ff    <= hbs_pkg::WORD_RST;
      bits_ff     <= '0;
      bits_ovf_ff <= 1'b0;
    end else if (sclk_fall && spi_ff == hbs_pkg::SPI_FRAME) begin
      // sample msb first on falling clock
      in_sr_ff <= {in_sr_ff[W-2:0], si_s};
      bits_ff  <= bits_ff + 1'b1;
      if (&bits_ff) begin
        bits_ovf_ff <= 1'b1;  // too long to judge, treat as invalid
      end
    end
  end

  // output shift register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_sr_ff <= hbs_pkg::WORD_RST;
      first_ff  <= 1'b1;
    end else if (cs_fall) begin
      out_sr_ff <= status;
      first_ff  <= 1'b1;
    end else if (sclk_rise && spi_ff == hbs_pkg::SPI_FRAME) begin
      first_ff <= 1'b0;
      if (!first_ff) begin
        // shift on rising clock, chain data follows
        out_sr_ff <= {out_sr_ff[W-2:0], in_sr_ff[0]};
      end
    end
  end

  // output pin; select is slow so these may be combinational
  always_comb begin
    so_oe = (spi_ff == hbs_pkg::SPI_FRAME) && !csn_s;
    if (first_ff) begin
      so = (|tsd_ff) | si_s;
    end else begin
      so = out_sr_ff[W-1];
    end
  end

  // ---------------------------------------------------------------
  // command path through the fifo
  // ---------------------------------------------------------------
  logic         pend_ff;
  logic [W-1:0] pend_word_ff;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [W-1:0] fifo_out_data;
  logic [NB-1:0] dead_busy;

  // pending word waits here while the fifo is full
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_ff      <= 1'b0;
      pend_word_ff <= hbs_pkg::WORD_RST;
    end else if (!en_s) begin
      pend_ff <= 1'b0;
    end else if (cs_rise && spi_ff == hbs_pkg::SPI_FRAME && frame_ok) begin
      // latest 16 bits kept even if stale
      pend_ff      <= 1'b1;
      pend_word_ff <= in_sr_ff;
    end else if (pend_ff && fifo_in_ready) begin
      pend_ff <= 1'b0;
    end
  end

  // stall applying while any bridge sits in dead time
  assign fifo_out_ready = !(|dead_busy);

  hbs_fifo #(
    .WIDTH (W),
    .DEPTH (hbs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst || !en_s),
    .in_valid  (pend_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_word_ff),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign clr = fifo_out_valid && fifo_out_ready
            && fifo_out_data[hbs_pkg::WORD_W-1];

  // command register loads from the fifo
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd_ff <= hbs_pkg::WORD_RST;
    end else if (!en_s) begin
      cmd_ff <= hbs_pkg::WORD_RST;
    end else if (fifo_out_valid && fifo_out_ready) begin
      cmd_ff <= fifo_out_data;
    end
  end

  // ---------------------------------------------------------------
  // bridge drivers with interlock
  // ---------------------------------------------------------------
  logic supply_off;

  assign supply_off = uv_det || (ov_det && cmd_ff.ovlo_en) || !en_s;

  generate
    for (genvar b = 0; b < NB; b++) begin : g_drv
      logic                      hs_ff;
      logic                      ls_ff;
      logic [hbs_pkg::DEAD_W-1:0] dt_ff;
      logic                      run;
      logic                      want_hs;
      logic                      want_ls;

      assign run = cmd_ff.bridge_enable_bit[b] && !supply_off
                && !oc_ff[b] && !tsd_ff[b]
                && !(uld_ff[b] && cmd_ff.uld_shutdown_en);
      assign want_hs = run && cmd_ff.bridge_config_bit[b];
      assign want_ls = run && !cmd_ff.bridge_config_bit[b];
      assign dead_busy[b] = (dt_ff != '0);

      // off first, wait dead time, then on
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          hs_ff <= 1'b0;
          ls_ff <= 1'b0;
          dt_ff <= '0;
        end else if ((hs_ff && !want_hs) || (ls_ff && !want_ls)) begin
          hs_ff <= hs_ff && want_hs;
          ls_ff <= ls_ff && want_ls;
          dt_ff <= hbs_pkg::DEAD_W'(DEAD_CYC);
        end else if (dt_ff != '0) begin
          dt_ff <= dt_ff - 1'b1;
        end else if (!hs_ff && !ls_ff) begin
          hs_ff <= want_hs;
          ls_ff <= want_ls;
        end
      end

      assign high_side_switch[b] = hs_ff;
      assign low_side_switch[b]  = ls_ff;
    end
  endgenerate

endmodule : hbs_core

`default_nettype wire

// [verif/hbs_checker.sv]
`timescale 1ns/10ps
`default_nettype none

module hbs_checker #(
  parameter int NB       = 6,
  parameter int DEAD_CYC = 10
) (
  // clock and reset
  input wire logic          clock,
  input wire logic          rst,
  // pins
  input wire logic          enable,
  input wire logic          sclk,
  input wire logic          chip_select_n,
  input wire logic          si,
  input wire logic          so,
  input wire logic          so_oe,
  // detectors
  input wire logic [NB-1:0] oc_det,
  input wire logic [NB-1:0] uld_det,
  input wire logic [NB-1:0] tsd_det,
  input wire logic          tw_det,
  input wire logic          uv_det,
  input wire logic          ov_det,
  // switches
  input wire logic [NB-1:0] high_side_switch,
  input wire logic [NB-1:0] low_side_switch
);
  // ----------
  // helper state
  // ----------
  logic [NB-1:0] hs_ff, ls_ff, off, rise, gap_ok;
  logic [7:0]    age_ff [NB];
  logic          sclk_ff, rise_seen_ff;

  // last switch state and first serial clock rise of a frame
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hs_ff        <= '0;
      ls_ff        <= '0;
      sclk_ff      <= 1'b0;
      rise_seen_ff <= 1'b0;
    end else begin
      hs_ff        <= high_side_switch;
      ls_ff        <= low_side_switch;
      sclk_ff      <= sclk;
      rise_seen_ff <= !chip_select_n && (rise_seen_ff || (sclk && !sclk_ff));
    end
  end

  assign off  = (hs_ff & ~high_side_switch) | (ls_ff & ~low_side_switch);
  assign rise = (~hs_ff & high_side_switch) | (~ls_ff & low_side_switch);

  // cycles since a side went off, saturating so idle bridges pass
  for (genvar i = 0; i < NB; i++) begin : g_age
    always_ff @(posedge clock or posedge rst) begin
      if (rst)
        age_ff[i] <= 8'hFF;
      else if (off[i])
        age_ff[i] <= 8'h01;
      else if (age_ff[i] != 8'hFF)
        age_ff[i] <= age_ff[i] + 8'h01;
    end
    assign gap_ok[i] = age_ff[i] >= 8'(DEAD_CYC);
  end

  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_select;
    $fell(chip_select_n) && enable;
  endsequence
  sequence s_pre_window;
    (si && so_oe && !rise_seen_ff) [*3];
  endsequence

  a_shoot_through: assert property (
    (high_side_switch & low_side_switch) == '0) else $error("both sides on");
  a_dead_gap: assert property (
    (rise & (off | ~gap_ok)) == '0) else $error("dead time too short");
  a_enable_clear: assert property (
    !enable [*4] |-> (high_side_switch | low_side_switch) == '0) else $error("enable low");
  a_idle_tristate: assert property (
    chip_select_n [*4] |-> !so_oe) else $error("output driven while deselected");
  a_select_drive: assert property (
    s_select |-> ##[2:4] so_oe) else $error("output not driven after select");
  a_pre_flag: assert property (
    s_pre_window |-> so) else $error("input not ored onto output");
  a_supply_off: assert property (
    uv_det [*3] |-> (high_side_switch | low_side_switch) == '0) else $error("undervoltage");
  a_fault_off: assert property (
    |oc_det |-> ##2 ((high_side_switch | low_side_switch) & $past(oc_det, 2)) == '0)
    else $error("overcurrent bridge on");
endmodule : hbs_checker

bind hbs_core hbs_checker #(.NB(NB), .DEAD_CYC(DEAD_CYC)) u_hbs_checker (
  .clock, .rst, .enable, .sclk, .chip_select_n, .si, .so, .so_oe, .oc_det, .uld_det,
  .tsd_det, .tw_det, .uv_det, .ov_det, .high_side_switch, .low_side_switch
);

`default_nettype wire

// [verif/hbs_host.sv]
`timescale 1ns/10ps
`default_nettype none

module hbs_host (
  // serial pins toward the device
  output logic     sclk,
  output logic     chip_select_n,
  output logic     si,
  input wire logic so,
  input wire logic so_oe
);
  // ----------
  // master frame
  // ----------
  // idle: select high, clock and data low (data has a pull-down)
  initial begin
    sclk          = 1'b0;
    chip_select_n = 1'b1;
    si            = 1'b0;
  end

  // n bits of d msb first; q collects output, pre the flag before clocking
  task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q,
                      output logic pre);
    q = '0;
    sclk = 1'b0;
    si = 1'b0;
    #537 chip_select_n = 1'b0;
    #600 pre = so_oe ? so : 1'bx;
    si = d[n-1];
    #400;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      #400 sclk = 1'b0;
      q[i] = so_oe ? so : 1'bx;
      #400 si = (i > 0) ? d[i-1] : 1'b0;
    end
    chip_select_n = 1'b1;
    #700;
  endtask : xfer
endmodule : hbs_host

`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ----------
  // signals and model state
  // ----------
  logic        clock = 1'b0, rst = 1'b1, enable = 1'b1;
  logic        tw_det = 1'b0, uv_det = 1'b0, ov_det = 1'b0;
  logic [5:0]  oc_det = '0, uld_det = '0, tsd_det = '0, hs, ls;
  logic        sclk, chip_select_n, si, so, so_oe, pre;
  logic [15:0] cmd = '0;
  logic [5:0]  oc_m = '0, uld_m = '0, tsd_m = '0;
  logic [31:0] q;
  int          n_fail = 0, samples_checked = 0;
  int          lens [6] = '{8, 15, 17, 20, 24, 31};

  // 10 MHz clock
  always #50 clock = ~clock;

  hbs_core u_hbs_core (.clock, .rst, .enable, .sclk, .chip_select_n, .si, .so, .so_oe,
    .oc_det, .uld_det, .tsd_det, .tw_det, .uv_det, .ov_det, .high_side_switch(hs),
    .low_side_switch(ls));
  hbs_host u_hbs_host (.sclk, .chip_select_n, .si, .so, .so_oe);

  // ----------
  // expectations
  // ----------
  // status word from the latch models and live levels
  function automatic logic [15:0] st();
    logic [15:0] w;
    w = {|oc_m, uv_det | ov_det, |uld_m, 12'h000, tw_det};
    for (int i = 0; i < 6; i++)
      w[2*i+1 +: 2] = oc_m[i] ? hbs_pkg::HB_OC : uld_m[i] ? hbs_pkg::HB_ULD :
                      cmd[7+i] ? hbs_pkg::HB_ON : hbs_pkg::HB_OFF;
    return w;
  endfunction : st

  // {high, low} switch commands; overcurrent, shutdown, underload with bit 13 set, or supply lockout forces off
  function automatic logic [15:0] drv();
    logic [5:0] on;
    on = cmd[12:7] & ~oc_m & ~tsd_m & ~(uld_m & {6{cmd[13]}});
    on &= {6{!uv_det && !(ov_det && cmd[0])}};
    return {4'h0, on & cmd[6:1], on & ~cmd[6:1]};
  endfunction : drv

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one frame, then the switches once dead time has passed
  task automatic frame(input int n, input logic [31:0] d);
    logic [15:0] e;
    e = st();
    d &= ~(32'hFFFF_FFFF << n);
    u_hbs_host.xfer(n, d, q, pre);
    check(16'(pre), 16'(|tsd_m));
    if (n >= 16)
      check(q[n-1 -: 16], e);
    if (n >= 16 && n % 8 == 0) begin
      if (n >= 24)
        check(16'(q & ~(32'hFFFF_FFFF << (n - 16))), 16'(d >> 16));
      cmd = d[15:0];
      if (d[15])
        {oc_m, uld_m, tsd_m} = '0;
    end
    repeat (40) @(posedge clock);
    check({4'h0, hs, ls}, drv());
  endtask : frame

  // one-cycle detector pulse: overcurrent, underload, shutdown
  task automatic pulse(input logic [5:0] o, input logic [5:0] u, input logic [5:0] t);
    @(posedge clock);
    {oc_det, uld_det, tsd_det} <= {o, u, t};
    @(posedge clock);
    {oc_det, uld_det, tsd_det} <= '0;
    oc_m |= o;
    uld_m |= u & ~oc_m;
    tsd_m |= t;
    repeat (40) @(posedge clock);
    check({4'h0, hs, ls}, drv());
  endtask : pulse

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(32'h1F60));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    check({4'h0, hs, ls}, '0);
    // random commands and supply levels
    for (int k = 0; k < 8; k++) begin
      tw_det <= 1'($urandom);
      // last pass always under undervoltage, so the lockout is seen at least once
      uv_det <= ($urandom % 4 == 0) || (k == 7);
      ov_det <= 1'($urandom);
      @(posedge clock);
      frame(16, $urandom & 32'h3FFF);
    end
    {uv_det, ov_det} <= 2'h0;
    @(posedge clock);  // supply levels settle before the next status snapshot
    // frame lengths, valid and not
    foreach (lens[k])
      frame(lens[k], $urandom);
    frame(32, {16'hA5C3, 16'h1F80});
    // underload then overcurrent, clears, shutdown flag
    pulse(6'h00, 6'h01, 6'h00);
    frame(16, 32'h1F80);
    pulse(6'h01, 6'h00, 6'h00);
    frame(16, 32'h1F80);
    pulse(6'h00, 6'h01, 6'h00);
    frame(16, 32'h9F80);
    frame(16, 32'h3F94);
    pulse(6'h00, 6'h03, 6'h00);
    pulse(6'h00, 6'h00, 6'h04);
    frame(16, 32'h9F80);
    frame(16, 32'h1F80);
    // enable low, then a second reset
    for (int k = 0; k < 2; k++) begin
      if (k == 0)
        enable <= 1'b0;
      else
        rst <= 1'b1;
      repeat (5) @(posedge clock);
      {cmd, oc_m, uld_m, tsd_m} = '0;
      check({4'h0, hs, ls}, '0);
      enable <= 1'b1;
      rst <= 1'b0;
      repeat (5) @(posedge clock);
      frame(16, 32'h0B41);
    end
    close_out();
  end

  // watchdog well past the expected run
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    close_out();
  end
endmodule : testbench

`default_nettype wire
